// *** verilog/iomd_pkg.sv ***
package iomd_pkg;
  // ==========================================================
  // Widths and reset values
  localparam int          IOMD_DATA_W   = 8;
  localparam int          IOMD_ADDR_W   = 7;
  localparam int          IOMD_FILE_N   = 128;
  localparam logic [7:0]  IOMD_ACC_RST  = 8'h00;
  localparam logic [7:0]  IOMD_FILE_RST = 8'h00;
  localparam logic        IOMD_ZERO_RST = 1'h0;
  localparam logic [6:0]  IOMD_ADDR_RST = 7'h00;
  localparam logic [7:0]  IOMD_ONE      = 8'h01;

  // ==========================================================
  // Operation codes
  typedef enum logic [2:0] {
    IOMD_NOP_OP,
    increment_file_op,
    or_with_file_op,
    move_file_op,
    store_accumulator_op,
    load_literal_op
  } iomd_op_e;

  // ==========================================================
  // One instruction as issued by the core
  typedef struct packed {
    logic       valid;
    iomd_op_e   op;
    logic [6:0] fileAddr;
    logic       destFile;
    logic [7:0] literal;
  } iomd_instr_s;
endpackage

// *** verilog/iomd_datapath.sv ***
// How it works
// - Increment adds one to addressed file byte, zero flag follows the result
// - Destination bit zero sends the result to the accumulator, file untouched
// - Destination bit one writes the result back into the addressed file
// - OR combines accumulator and file, routed by destination, zero flag updated
// - Move copies file unchanged to accumulator or back to itself
// - Move updates zero flag from the moved value, giving a zero test
// - Store writes accumulator into file and leaves flags alone
// - Literal load puts the immediate byte into accumulator, flags unchanged
module iomd_datapath
  import iomd_pkg::*;
#(
  parameter int FILE_N = IOMD_FILE_N
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Instruction issue
  input  wire iomd_instr_s instr,
  // Architectural state
  output logic [7:0]       accOut,
  output logic             zeroFlag,
  // Write-back observation
  output logic             fileWrEn,
  output logic [6:0]       fileWrAddr,
  output logic [7:0]       fileWrData
);

  // ==========================================================
  // State
  logic [7:0] fileMem_reg [FILE_N];
  logic [7:0] acc_reg;
  logic       zero_reg;
  logic [7:0] fileRd;    // Byte at the issued address
  logic [7:0] result;    // Value that this instruction produces
  logic       toFile;    // Result goes back to the file
  logic       toAcc;     // Result goes to the accumulator
  logic       setsZero;  // Instruction updates the zero flag

  // Read is combinational, so a byte written at one edge is seen by the next instruction
  assign fileRd = fileMem_reg[instr.fileAddr];

  // ==========================================================
  // Result select; single combinational pass keeps it one cycle
  always_comb begin
    result   = fileRd;
    toFile   = 1'h0;
    toAcc    = 1'h0;
    setsZero = 1'h0;
    if (instr.valid) begin
      case (instr.op)
        // Byte operations route by the destination bit and update zero
        increment_file_op: begin
          result   = fileRd + IOMD_ONE;
          toFile   = instr.destFile;
          toAcc    = !instr.destFile;
          setsZero = 1'h1;
        end
        or_with_file_op: begin
          result   = acc_reg | fileRd;
          toFile   = instr.destFile;
          toAcc    = !instr.destFile;
          setsZero = 1'h1;
        end
        move_file_op: begin
          result   = fileRd;
          toFile   = instr.destFile;
          toAcc    = !instr.destFile;
          setsZero = 1'h1;
        end
        // Store has no destination bit of its own: it always writes the file
        store_accumulator_op: begin
          result = acc_reg;
          toFile = 1'h1;
        end
        // Literal load touches only the accumulator, never the flags
        load_literal_op: begin
          result = instr.literal;
          toAcc  = 1'h1;
        end
        // No-op and unused codes change nothing
        default: begin
          result = fileRd;
        end
      endcase
    end
  end

  // ==========================================================
  // File register array; no reset so it maps onto plain storage
  always_ff @(posedge clk_sys) begin
    if (toFile) begin
      fileMem_reg[instr.fileAddr] <= result;
    end
  end

  // ==========================================================
  // Accumulator, written in the same cycle the instruction issues
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_reg <= IOMD_ACC_RST;
    end else if (toAcc) begin
      acc_reg <= result;
    end
  end

  // ==========================================================
  // Zero flag, held when the operation does not affect status
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zero_reg <= IOMD_ZERO_RST;
    end else if (setsZero) begin
      zero_reg <= (result == 8'h00);
    end
  end

  // ==========================================================
  // Registered write-back echo for observation
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fileWrEn   <= 1'h0;
      fileWrAddr <= IOMD_ADDR_RST;
      fileWrData <= IOMD_FILE_RST;
    end else begin
      fileWrEn   <= toFile;
      fileWrAddr <= instr.fileAddr;
      fileWrData <= result;
    end
  end

  // Outputs come straight from the registers, so they never glitch
  assign accOut   = acc_reg;
  assign zeroFlag = zero_reg;

  // ==========================================================
  // Checks

  // Increment to the accumulator, the wrap from FF included
  a_inc_result: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == increment_file_op && !instr.destFile)
      |=> (accOut == $past(fileRd) + 8'h01))
    else $error("increment result wrong");

  // Wrap to zero must raise the zero flag
  a_inc_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == increment_file_op && fileRd == 8'hFF) |=> zeroFlag)
    else $error("increment wrap did not set zero");

  // Any other increment leaves a non-zero result, so zero must drop
  a_inc_nonzero: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == increment_file_op && fileRd != 8'hFF) |=> !zeroFlag)
    else $error("increment left zero flag set");

  // Apart from store, destination zero must never reach the file
  a_dest_acc_file: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op != store_accumulator_op && !instr.destFile) |=> !fileWrEn)
    else $error("file written with destination zero");

  // Increment with destination one writes the file and leaves the accumulator alone
  a_dest_file: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == increment_file_op && instr.destFile)
      |=> (fileWrEn && fileWrData == $past(fileRd) + 8'h01 && $stable(accOut)))
    else $error("write-back to file wrong");

  // Every file write lands at the address that was issued
  a_wr_target: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && (instr.op == store_accumulator_op
      || (instr.destFile && (instr.op == increment_file_op || instr.op == or_with_file_op
      || instr.op == move_file_op))))
      |=> (fileWrEn && fileWrAddr == $past(instr.fileAddr)))
    else $error("file write address wrong");

  // OR into the accumulator, with the zero flag from the result
  a_or_result: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == or_with_file_op && !instr.destFile)
      |=> (accOut == ($past(accOut) | $past(fileRd)) && zeroFlag == (accOut == 8'h00)))
    else $error("or result wrong");

  // OR back into the file keeps the accumulator
  a_or_back: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == or_with_file_op && instr.destFile)
      |=> (fileWrEn && fileWrData == ($past(accOut) | $past(fileRd)) && $stable(accOut)))
    else $error("or write-back wrong");

  // Move to the accumulator is an exact copy
  a_move_copy: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == move_file_op && !instr.destFile) |=> (accOut == $past(fileRd)))
    else $error("move did not copy");

  // Move back to itself rewrites the same byte and keeps the accumulator
  a_move_back: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == move_file_op && instr.destFile)
      |=> (fileWrEn && fileWrData == $past(fileRd) && $stable(accOut)))
    else $error("move write-back wrong");

  // Move doubles as a zero test whatever the destination
  a_move_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == move_file_op) |=> (zeroFlag == ($past(fileRd) == 8'h00)))
    else $error("move zero flag wrong");

  // Store writes the accumulator out and keeps the flag
  a_store_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == store_accumulator_op)
      |=> (fileWrEn && fileWrData == $past(accOut) && $stable(zeroFlag)))
    else $error("store wrong");

  // Store must not disturb the accumulator it copies
  a_store_keeps_acc: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == store_accumulator_op) |=> $stable(accOut))
    else $error("store changed accumulator");

  // Literal load reaches the accumulator and keeps the flag
  a_literal_load: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == load_literal_op)
      |=> (accOut == $past(instr.literal) && $stable(zeroFlag)))
    else $error("literal load wrong");

  // Literal load never writes the file, whatever the destination bit says
  a_literal_no_file: assert property (@(posedge clk_sys) disable iff (rst)
    (instr.valid && instr.op == load_literal_op) |=> !fileWrEn)
    else $error("literal load wrote file");

  // An idle or no-op cycle leaves every piece of state as it was
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (!instr.valid || instr.op == IOMD_NOP_OP)
      |=> (!fileWrEn && $stable(accOut) && $stable(zeroFlag)))
    else $error("idle cycle changed state");
endmodule

// *** sim/iomd_datapath_test.sv ***
module iomd_datapath_test import iomd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // One row: issued instruction and the outputs one edge later
  typedef struct packed {
    iomd_instr_s instr;
    logic [7:0]  acc;
    logic        zero;
    logic        wr;
    logic [7:0]  data;
  } iomd_row_s;
  logic        clk_sys;
  logic        rst;
  iomd_instr_s instr;
  logic [7:0]  accOut;
  logic        zeroFlag;
  logic        fileWrEn;
  logic [6:0]  fileWrAddr;
  logic [7:0]  fileWrData;
  int          errors;
  int          checked;
  iomd_row_s   rows [20];
  iomd_datapath dut (.clk_sys(clk_sys), .rst(rst), .instr(instr), .accOut(accOut), .zeroFlag(zeroFlag),
    .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));
  // Clock at 100 MHz
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Builds one row: instruction fields first, then the outputs expected one edge later
  function automatic iomd_row_s mk(logic v, iomd_op_e op, logic [6:0] a, logic d, logic [7:0] lit,
                                   logic [7:0] acc, logic z, logic wr, logic [7:0] data);
    mk = '{'{v, op, a, d, lit}, acc, z, wr, data};
  endfunction
  // Compares one output; !== so an unknown value counts as a mismatch
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict; the only place where the run ends
  task automatic results();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the whole run needs well under a microsecond
  initial begin
    #5000;
    errors++;
    results();
  end
  // ==========================================================
  // Main sequence; file bytes are written before they are read, since the array is not reset
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'h1;
    instr = '0;
    // Columns: valid, operation, address, destination, literal, then accumulator, zero, write, data
    rows = '{
      mk(1'h1, load_literal_op,      7'h00, 1'h0, 8'h4F, 8'h4F, 1'h0, 1'h0, 8'h00),
      mk(1'h1, store_accumulator_op, 7'h05, 1'h0, 8'h00, 8'h4F, 1'h0, 1'h1, 8'h4F),
      mk(1'h1, load_literal_op,      7'h00, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00),
      mk(1'h1, store_accumulator_op, 7'h7F, 1'h0, 8'h00, 8'h00, 1'h0, 1'h1, 8'h00),
      mk(1'h1, move_file_op,         7'h7F, 1'h1, 8'h00, 8'h00, 1'h1, 1'h1, 8'h00),
      mk(1'h1, load_literal_op,      7'h00, 1'h0, 8'hFF, 8'hFF, 1'h1, 1'h0, 8'h00),
      mk(1'h1, store_accumulator_op, 7'h10, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h1, 8'hFF),
      mk(1'h1, increment_file_op,    7'h10, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00),
      mk(1'h1, increment_file_op,    7'h10, 1'h1, 8'h00, 8'h00, 1'h1, 1'h1, 8'h00),
      mk(1'h1, increment_file_op,    7'h10, 1'h1, 8'h00, 8'h00, 1'h0, 1'h1, 8'h01),
      mk(1'h1, or_with_file_op,      7'h05, 1'h0, 8'h00, 8'h4F, 1'h0, 1'h0, 8'h00),
      mk(1'h1, or_with_file_op,      7'h7F, 1'h1, 8'h00, 8'h4F, 1'h0, 1'h1, 8'h4F),
      mk(1'h0, increment_file_op,    7'h10, 1'h1, 8'h00, 8'h4F, 1'h0, 1'h0, 8'h00),
      mk(1'h1, IOMD_NOP_OP,          7'h10, 1'h1, 8'h00, 8'h4F, 1'h0, 1'h0, 8'h00),
      mk(1'h1, move_file_op,         7'h10, 1'h0, 8'h00, 8'h01, 1'h0, 1'h0, 8'h00),
      mk(1'h1, store_accumulator_op, 7'h20, 1'h1, 8'h00, 8'h01, 1'h0, 1'h1, 8'h01),
      mk(1'h1, load_literal_op,      7'h00, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00),
      mk(1'h1, store_accumulator_op, 7'h30, 1'h0, 8'h00, 8'h00, 1'h0, 1'h1, 8'h00),
      mk(1'h1, or_with_file_op,      7'h30, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00),
      mk(1'h1, load_literal_op,      7'h00, 1'h0, 8'hA5, 8'hA5, 1'h1, 1'h0, 8'h00)
    };
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'h0;
    // Back to back, one instruction each cycle, outputs checked one edge later
    foreach (rows[i]) begin
      instr = rows[i].instr;
      @(posedge clk_sys);
      #1;
      chk("accOut", rows[i].acc, accOut);
      chk("zeroFlag", rows[i].zero, zeroFlag);
      chk("fileWrEn", rows[i].wr, fileWrEn);
      if (rows[i].wr) begin
        chk("fileWrAddr", rows[i].instr.fileAddr, fileWrAddr);
        chk("fileWrData", rows[i].data, fileWrData);
      end
    end
    // Reset in mid-run acts at once, without a clock edge
    instr = '0;
    rst = 1'h1;
    #1;
    chk("accOut", IOMD_ACC_RST, accOut);
    chk("zeroFlag", IOMD_ZERO_RST, zeroFlag);
    chk("fileWrEn", 8'h00, fileWrEn);
    chk("fileWrAddr", IOMD_ADDR_RST, fileWrAddr);
    chk("fileWrData", IOMD_FILE_RST, fileWrData);
    @(posedge clk_sys);
    #1 rst = 1'h0;
    // First instruction after release is taken at the very next edge
    instr = '{1'h1, load_literal_op, 7'h00, 1'h1, 8'h5A};
    @(posedge clk_sys);
    #1;
    chk("accOut", 8'h5A, accOut);
    chk("zeroFlag", 8'h00, zeroFlag);
    chk("fileWrEn", 8'h00, fileWrEn);
    // The file is not reset: the byte counted up before reset must still be there
    instr = '{1'h1, move_file_op, 7'h10, 1'h1, 8'h00};
    @(posedge clk_sys);
    #1;
    chk("accOut", 8'h5A, accOut);
    chk("zeroFlag", 8'h00, zeroFlag);
    chk("fileWrEn", 8'h01, fileWrEn);
    chk("fileWrAddr", 8'h10, fileWrAddr);
    chk("fileWrData", 8'h01, fileWrData);
    results();
  end
endmodule
